// file: link_pkg.sv
// Shared constants and types for the output-pin programming link
package link_pkg;
  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_MHZ = 50;
  localparam int BIT_SLOW_US = 1000;
  localparam int BIT_FAST_US = 250;
  localparam int BIT_SLOW_CYC = BIT_SLOW_US * CLK_MHZ;
  localparam int BIT_FAST_CYC = BIT_FAST_US * CLK_MHZ;
  localparam int ENTRY_US = 20;
  localparam int ENTRY_CYC = ENTRY_US * CLK_MHZ;
  localparam int CNT_W = 18;
  // ------------------------------------------------------------
  // Telegram layout
  // ------------------------------------------------------------
  localparam int DATA_W = 16;
  localparam int FRAME_BITS = 22;
  localparam int ACK_BITS = 2;
  localparam int NB_W = 5;
  localparam int MEM_N = 5;
  localparam logic [2:0] CMD_READ = 3'h1;
  localparam logic [2:0] CMD_WRITE = 3'h2;
  localparam logic [2:0] CMD_STORE = 3'h3;
  localparam logic [2:0] ADR_CFG = 3'h0;
  localparam logic [2:0] ADR_ANGLE = 3'h5;
  localparam logic [2:0] ADR_PFAULT = 3'h6;
  localparam logic [2:0] ADR_DIAG = 3'h7;
  localparam logic [15:0] MEM_RST = 16'h0000;
  // Configuration word bits
  localparam int CFG_LOCK = 15;
  localparam int CFG_FINAL_OUTPUT_SELECT_BIT = 14;
  localparam int CFG_FAST = 13;
  localparam int CFG_HOLD = 12;
  localparam int CFG_CLAMP = 11;
  // Programming fault record bits
  localparam int PF_LOCKED = 0;
  localparam int PF_CMD = 1;
  localparam int PF_ADR = 2;
  localparam int PF_FRAME = 3;
  // ------------------------------------------------------------
  // Register map and events
  // ------------------------------------------------------------
  localparam logic [7:0] REG_STATE = 8'h00;
  localparam logic [7:0] REG_IRQ_STAT = 8'h04;
  localparam logic [7:0] REG_IRQ_MASK = 8'h08;
  localparam logic [7:0] REG_CFG = 8'h0C;
  localparam int EV_N = 4;
  localparam int EV_ENTRY = 0;
  localparam int EV_FRAME = 1;
  localparam int EV_FAULT = 2;
  localparam int EV_STORE = 3;
  // Gray-coded along application, listen, execute, turnaround, reply
  typedef enum logic [2:0] {
    S_APP = 3'b000,
    S_LISTEN = 3'b001,
    S_EXEC = 3'b011,
    S_TURN = 3'b010,
    S_REPLY = 3'b110
  } state_t;
endpackage : link_pkg

// file: link_rx.sv
// Bit decoder for the single-wire telegram
`timescale 1ns/1ps
module link_rx
  import link_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic enable,
  input wire logic line,
  input wire logic [CNT_W-1:0] bit_cyc,
  output logic bit_vld,
  output logic bit_val,
  output logic frame_end
);
  logic prev_q, active_q, mid_q;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] three_q;
  logic edge_seen;
  assign edge_seen = line != prev_q;
  // Edges before three quarters of a bit are mid-bit ones; later ones close the bit
  always_ff @(posedge clk) begin
    three_q <= bit_cyc - (bit_cyc >> 2);
  end
  // Edge classification; silence for two bit times ends the telegram
  always_ff @(posedge clk) begin
    bit_vld <= 1'b0;
    frame_end <= 1'b0;
    if (!rst_n || !enable) begin
      prev_q <= 1'b1;
      active_q <= 1'b0;
      mid_q <= 1'b0;
      cnt_q <= '0;
    end else begin
      prev_q <= line;
      if (edge_seen && !active_q) begin
        active_q <= 1'b1;
        cnt_q <= '0;
        mid_q <= 1'b0;
      end else if (edge_seen && cnt_q < three_q) begin
        mid_q <= 1'b1;
        cnt_q <= cnt_q + 1'b1;
      end else if (edge_seen) begin
        bit_vld <= 1'b1;
        bit_val <= mid_q;
        mid_q <= 1'b0;
        cnt_q <= '0;
      end else if (active_q) begin
        cnt_q <= cnt_q + 1'b1;
        if (cnt_q == (bit_cyc << 1)) begin
          frame_end <= 1'b1;
          active_q <= 1'b0;
        end
      end
    end
  end
endmodule : link_rx

// file: link_tx.sv
// Bit encoder that modulates the reply onto the pin
`timescale 1ns/1ps
module link_tx
  import link_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic [NB_W-1:0] nbits,
  input wire logic [DATA_W-1:0] word,
  input wire logic [CNT_W-1:0] bit_cyc,
  output logic line_o,
  output logic busy
);
  logic [CNT_W-1:0] cnt_q;
  logic [NB_W-1:0] idx_q;
  logic cur;
  assign cur = word[idx_q[3:0]];
  // Leading edge marks the first bit; every bit ends in an edge
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      line_o <= 1'b1;
      busy <= 1'b0;
      cnt_q <= '0;
      idx_q <= '0;
    end else if (start && !busy) begin
      line_o <= ~line_o;
      busy <= 1'b1;
      cnt_q <= '0;
      idx_q <= nbits - 1'b1;
    end else if (busy) begin
      cnt_q <= cnt_q + 1'b1;
      if (cnt_q == bit_cyc - 1'b1) begin
        line_o <= ~line_o;
        cnt_q <= '0;
        if (idx_q == '0) busy <= 1'b0;
        else idx_q <= idx_q - 1'b1;
      end else if (cnt_q == (bit_cyc >> 1) - 1'b1 && cur) begin
        line_o <= ~line_o;
      end
    end else begin
      line_o <= 1'b1; // Idle high matches the pull-up, so driving starts without a step
    end
  end
  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  property p_zero_holds;
    @(posedge clk) disable iff (!rst_n)
    busy && !start && !cur && cnt_q == (bit_cyc >> 1) - 1'b1 |=> line_o == $past(line_o);
  endproperty
  a_zero_holds: assert property (p_zero_holds) else $error("zero bit toggled mid-bit");
  property p_bit_edge;
    @(posedge clk) disable iff (!rst_n)
    busy && cnt_q == bit_cyc - 1'b1 |=> line_o != $past(line_o);
  endproperty
  a_bit_edge: assert property (p_bit_edge) else $error("bit end without edge");
endmodule : link_tx

// file: link_top.sv
// Programming link multiplexed onto the sensor output pin
// Behaviour
// - Power-up always lands in application mode
// - Overdrive pulse on pin enters programming
// - Device answers by driving the pin
// - Zero bit: no level change inside
// - One bit: level change at half
// - Every bit ends with a level change
// - Slow bit time 1000 us, bit13 clear
// - Fast bit time 250 us, bit13 set
// - Link carries memory, error codes, angle
// - Write and store answer two acknowledges
// - Fault hold makes second acknowledge fail
// - Lock bit status readable after locking
//
// The APB slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module link_top
  import link_pkg::*;
#(
  parameter int SLOW_CYC = BIT_SLOW_CYC,
  parameter int FAST_CYC = BIT_FAST_CYC
) (
  input wire logic MCLK,
  input wire logic RESET_N,
  input wire logic PIN_I,
  output logic PIN_O,
  output logic PIN_OE_N,
  input wire logic APP_LEVEL,
  input wire logic [11:0] ANGLE,
  input wire logic [15:0] ERR_CODE,
  output logic PROG_MODE,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  output logic IRQ
);
  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  state_t st_q;
  logic pin_m_q, pin_s_q;
  logic drv1_q, drv2_q, oe1_q, oe2_q;
  logic [CNT_W-1:0] mis_q, turn_q, bit_cyc;
  logic [DATA_W-1:0] mem_q [MEM_N];
  logic [DATA_W-1:0] nvm_q [MEM_N];
  logic [DATA_W-1:0] pf_q;
  logic [FRAME_BITS-1:0] frm_q;
  logic [NB_W-1:0] nb_q;
  logic [DATA_W-1:0] tx_word_q;
  logic [NB_W-1:0] tx_n_q;
  logic tx_start_q, tx_busy, tx_line;
  logic bit_vld, bit_val, frame_end;
  logic [2:0] cmd, adr;
  logic [DATA_W-1:0] dat;
  logic bad_frame, bad_cmd, bad_adr, locked, hold, err, wr_ok, st_ok;
  logic [EV_N-1:0] ev, irq_stat_q, irq_mask_q;
  logic apb_acc, apb_wr;
  // ------------------------------------------------------------
  // Pin synchroniser and entry pulse detection
  // ------------------------------------------------------------
  // Two stages before any logic looks at the pin
  always_ff @(posedge MCLK) begin
    pin_m_q <= PIN_I;
    pin_s_q <= pin_m_q;
  end
  // Driven level delayed to line up with the synchronised pin
  always_ff @(posedge MCLK) begin
    drv1_q <= PIN_O;
    drv2_q <= drv1_q;
  end
  // Drive enable delayed alike; the decoder must not hear the tail of our own reply
  always_ff @(posedge MCLK) begin
    oe1_q <= PIN_OE_N;
    oe2_q <= oe1_q;
  end
  // Count cycles in which the programmer overrides our level
  always_ff @(posedge MCLK) begin
    if (!RESET_N || st_q != S_APP || pin_s_q == drv2_q) mis_q <= '0;
    else if (mis_q != CNT_W'(ENTRY_CYC)) mis_q <= mis_q + 1'b1;
  end
  // ------------------------------------------------------------
  // Telegram field decode
  // ------------------------------------------------------------
  assign cmd = frm_q[21:19];
  assign adr = frm_q[18:16];
  assign dat = frm_q[15:0];
  assign locked = nvm_q[0][CFG_LOCK];
  assign hold = mem_q[0][CFG_HOLD];
  assign bad_frame = nb_q != NB_W'(FRAME_BITS);
  assign bad_cmd = cmd != CMD_READ && cmd != CMD_WRITE && cmd != CMD_STORE;
  assign bad_adr = cmd == CMD_WRITE && adr >= ADR_ANGLE;
  // Locked parts refuse to change memory
  assign wr_ok = st_q == S_EXEC && !bad_frame && cmd == CMD_WRITE && !bad_adr && !locked;
  assign st_ok = st_q == S_EXEC && !bad_frame && cmd == CMD_STORE && !locked;
  assign err = bad_cmd || bad_adr || (locked && cmd != CMD_READ);
  // Stored setting picks the bit time; a live write would break the link mid-session
  assign bit_cyc = nvm_q[0][CFG_FAST] ? CNT_W'(FAST_CYC) : CNT_W'(SLOW_CYC);
  // ------------------------------------------------------------
  // Mode and telegram sequencer
  // ------------------------------------------------------------
  // Only a reset leaves programming mode
  always_ff @(posedge MCLK) begin
    tx_start_q <= 1'b0;
    if (!RESET_N) begin
      st_q <= S_APP;
      nb_q <= '0;
      frm_q <= '0;
      turn_q <= '0;
    end else begin
      case (st_q)
        S_APP: begin
          if (mis_q == CNT_W'(ENTRY_CYC)) st_q <= S_LISTEN;
        end
        S_LISTEN: begin
          if (bit_vld) begin
            frm_q <= {frm_q[FRAME_BITS-2:0], bit_val};
            if (nb_q != '1) nb_q <= nb_q + 1'b1;
          end
          if (frame_end) st_q <= S_EXEC;
        end
        S_EXEC: begin
          nb_q <= '0;
          turn_q <= '0;
          // A broken telegram gets no answer at all
          st_q <= bad_frame ? S_LISTEN : S_TURN;
        end
        S_TURN: begin
          turn_q <= turn_q + 1'b1;
          if (turn_q == bit_cyc) begin
            tx_start_q <= 1'b1;
            st_q <= S_REPLY;
          end
        end
        S_REPLY: begin
          if (!tx_start_q && !tx_busy) st_q <= S_LISTEN;
        end
        default: st_q <= S_APP;
      endcase
    end
  end
  // Reply content: read data or the two acknowledges
  always_ff @(posedge MCLK) begin
    if (!RESET_N) begin
      tx_word_q <= '0;
      tx_n_q <= '0;
    end else if (st_q == S_EXEC) begin
      if (cmd == CMD_READ) begin
        tx_n_q <= NB_W'(DATA_W);
        case (adr)
          ADR_ANGLE: tx_word_q <= {4'h0, ANGLE};
          ADR_PFAULT: tx_word_q <= pf_q;
          ADR_DIAG: tx_word_q <= ERR_CODE;
          ADR_CFG: tx_word_q <= {nvm_q[0][CFG_LOCK], mem_q[0][14:0]};
          default: tx_word_q <= mem_q[adr];
        endcase
      end else begin
        tx_n_q <= NB_W'(ACK_BITS);
        // Second acknowledge fails only when the fault hold is armed
        tx_word_q <= {14'h0, !bad_cmd, !(err && hold)};
      end
    end
  end
  // ------------------------------------------------------------
  // Memory: working copy and stored copy per entry
  // ------------------------------------------------------------
  for (genvar i = 0; i < MEM_N; i++) begin : g_mem
    always_ff @(posedge MCLK) begin
      if (!RESET_N) begin
        mem_q[i] <= MEM_RST;
      end else if (wr_ok && adr == 3'(i)) begin
        mem_q[i] <= dat;
      end
    end
    // Stored copy survives only until the next reset here
    always_ff @(posedge MCLK) begin
      if (!RESET_N) nvm_q[i] <= MEM_RST;
      else if (st_ok) nvm_q[i] <= mem_q[i];
    end
  end
  // Fault record is sticky until the programmer reads it back
  always_ff @(posedge MCLK) begin
    if (!RESET_N) begin
      pf_q <= '0;
    end else if (st_q == S_EXEC) begin
      if (cmd == CMD_READ && adr == ADR_PFAULT && !bad_frame) pf_q <= '0;
      if (bad_frame) pf_q[PF_FRAME] <= 1'b1;
      else begin
        if (locked && cmd != CMD_READ) pf_q[PF_LOCKED] <= 1'b1;
        if (bad_cmd) pf_q[PF_CMD] <= 1'b1;
        if (bad_adr) pf_q[PF_ADR] <= 1'b1;
      end
    end
  end
  // ------------------------------------------------------------
  // Bit coders
  // ------------------------------------------------------------
  // Decoder listens only once the released pin has passed the synchroniser
  link_rx u_rx (
    .clk(MCLK),
    .rst_n(RESET_N),
    .enable(st_q == S_LISTEN && oe2_q),
    .line(pin_s_q),
    .bit_cyc(bit_cyc),
    .bit_vld(bit_vld),
    .bit_val(bit_val),
    .frame_end(frame_end)
  );
  link_tx u_tx (
    .clk(MCLK),
    .rst_n(RESET_N),
    .start(tx_start_q),
    .nbits(tx_n_q),
    .word(tx_word_q),
    .bit_cyc(bit_cyc),
    .line_o(tx_line),
    .busy(tx_busy)
  );
  // Pin drive: sensor level in application, reply only while answering
  always_ff @(posedge MCLK) begin
    if (!RESET_N) begin
      PIN_O <= 1'b1;
      PIN_OE_N <= 1'b0;
      PROG_MODE <= 1'b0;
    end else begin
      PIN_O <= st_q == S_APP ? APP_LEVEL : tx_line;
      PIN_OE_N <= !(st_q == S_APP || st_q == S_REPLY);
      PROG_MODE <= st_q != S_APP;
    end
  end
  // ------------------------------------------------------------
  // APB slave and interrupts
  // ------------------------------------------------------------
  assign apb_acc = PSEL && PENABLE && !PREADY;
  // Writes land at the edge that completes the transfer, with PREADY seen high
  assign apb_wr = PSEL && PENABLE && PREADY && PWRITE;
  assign ev[EV_ENTRY] = st_q == S_APP && mis_q == CNT_W'(ENTRY_CYC);
  assign ev[EV_FRAME] = frame_end && st_q == S_LISTEN;
  assign ev[EV_FAULT] = st_q == S_EXEC && (bad_frame || err);
  assign ev[EV_STORE] = st_ok;
  // One wait state; unmapped addresses answer with an error
  always_ff @(posedge MCLK) begin
    if (!RESET_N) begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA <= 32'h00000000;
    end else begin
      PREADY <= apb_acc;
      PSLVERR <= 1'b0;
      PRDATA <= 32'h00000000;
      if (apb_acc) begin
        case (PADDR)
          REG_STATE: PRDATA <= {27'h0, st_q, locked, st_q != S_APP};
          REG_IRQ_STAT: PRDATA <= {28'h0, irq_stat_q};
          REG_IRQ_MASK: PRDATA <= {28'h0, irq_mask_q};
          REG_CFG: PRDATA <= {16'h0, nvm_q[0]};
          default: PSLVERR <= 1'b1;
        endcase
      end
    end
  end
  // Sticky events, write one to clear; a new event beats the clear
  always_ff @(posedge MCLK) begin
    if (!RESET_N) irq_stat_q <= '0;
    else if (apb_wr && PADDR == REG_IRQ_STAT)
      irq_stat_q <= (irq_stat_q & ~PWDATA[EV_N-1:0]) | ev;
    else irq_stat_q <= irq_stat_q | ev;
  end
  // Mask register
  always_ff @(posedge MCLK) begin
    if (!RESET_N) irq_mask_q <= '0;
    else if (apb_wr && PADDR == REG_IRQ_MASK) irq_mask_q <= PWDATA[EV_N-1:0];
  end
  // Level interrupt
  always_ff @(posedge MCLK) begin
    if (!RESET_N) IRQ <= 1'b0;
    else IRQ <= |(irq_stat_q & irq_mask_q);
  end
  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  sequence s_exec_cmd(logic [2:0] c);
    st_q == S_EXEC && !bad_frame && cmd == c;
  endsequence
  property p_app_start;
    @(posedge MCLK) disable iff (!RESET_N) $rose(RESET_N) |-> st_q == S_APP && !PROG_MODE;
  endproperty
  a_app_start: assert property (p_app_start) else $error("not in application after reset");
  property p_entry;
    @(posedge MCLK) disable iff (!RESET_N)
    st_q == S_APP && mis_q == CNT_W'(ENTRY_CYC) |=> st_q == S_LISTEN ##1 PROG_MODE && PIN_OE_N;
  endproperty
  a_entry: assert property (p_entry) else $error("entry pulse ignored");
  property p_drive;
    @(posedge MCLK) disable iff (!RESET_N) $rose(tx_busy) |=> !PIN_OE_N && PIN_O == $past(tx_line);
  endproperty
  a_drive: assert property (p_drive) else $error("reply not driven");
  // Turnaround lasts one bit time plus one cycle of the stored setting, counted by turn_q from 0 up to bit_cyc
  property p_slow;
    @(posedge MCLK) disable iff (!RESET_N)
    st_q == S_TURN && !nvm_q[0][CFG_FAST] && turn_q == CNT_W'(SLOW_CYC) |=> tx_start_q;
  endproperty
  a_slow: assert property (p_slow) else $error("slow bit time wrong");
  property p_fast;
    @(posedge MCLK) disable iff (!RESET_N)
    st_q == S_TURN && nvm_q[0][CFG_FAST] && turn_q == CNT_W'(FAST_CYC) |=> tx_start_q;
  endproperty
  a_fast: assert property (p_fast) else $error("fast bit time wrong");
  property p_angle;
    @(posedge MCLK) disable iff (!RESET_N)
    s_exec_cmd(CMD_READ) ##0 adr == ADR_ANGLE |=> tx_word_q[11:0] == $past(ANGLE);
  endproperty
  a_angle: assert property (p_angle) else $error("angle not returned");
  property p_acks;
    @(posedge MCLK) disable iff (!RESET_N)
    s_exec_cmd(CMD_WRITE) ##0 !err |=> tx_n_q == NB_W'(ACK_BITS) && tx_word_q[1:0] == 2'h3
      && st_q == S_TURN;
  endproperty
  a_acks: assert property (p_acks) else $error("acknowledges missing");
  property p_hold_fail;
    @(posedge MCLK) disable iff (!RESET_N)
    s_exec_cmd(CMD_STORE) ##0 locked && hold |=> !tx_word_q[0];
  endproperty
  a_hold_fail: assert property (p_hold_fail) else $error("second ack not failed");
  property p_lock_read;
    @(posedge MCLK) disable iff (!RESET_N)
    s_exec_cmd(CMD_READ) ##0 adr == ADR_CFG |=> tx_word_q[CFG_LOCK] == $past(locked);
  endproperty
  a_lock_read: assert property (p_lock_read) else $error("lock status wrong");
  property p_locked_keep;
    @(posedge MCLK) disable iff (!RESET_N)
    s_exec_cmd(CMD_WRITE) ##0 locked |=> mem_q[0] == $past(mem_q[0])
      && mem_q[1] == $past(mem_q[1]) && nvm_q[0] == $past(nvm_q[0]);
  endproperty
  a_locked_keep: assert property (p_locked_keep) else $error("locked memory changed");
endmodule : link_top

// file: link_prog_model.sv
// Behavioural programmer that drives and listens on the shared output pin
`timescale 1ns/1ps
module link_prog_model (
  input wire logic clk,
  input wire logic line,
  input wire logic dev_oe_n,
  output logic drv_o,
  output logic drv_en
);
  // ------------------------------------------------------------
  // State of the programmer
  // ------------------------------------------------------------
  int bt = 40;
  int bad_time = 0;
  initial begin
    drv_o = 1'b1;
    drv_en = 1'b0;
  end

  // Overdrive the pin with a fixed level for n cycles
  task automatic pulse(input logic lvl, input int n);
    @(posedge clk);
    drv_o <= lvl;
    drv_en <= 1'b1;
    repeat (n) @(posedge clk);
    drv_en <= 1'b0;
    drv_o <= 1'b1;
  endtask : pulse

  // Send nb bits MSB first; release only inside the turnaround gap
  task automatic send(input logic [21:0] w, input int nb);
    logic lv;
    int i;
    lv = 1'b1;
    @(posedge clk);
    drv_en <= 1'b1;
    drv_o <= 1'b1;
    repeat (bt) @(posedge clk);
    lv = ~lv;
    drv_o <= lv;
    for (i = nb - 1; i >= 0; i--) begin
      if (w[i]) begin
        repeat (bt / 2) @(posedge clk);
        lv = ~lv;
        drv_o <= lv;
        repeat (bt - bt / 2) @(posedge clk);
      end else begin
        repeat (bt) @(posedge clk);
      end
      lv = ~lv;
      drv_o <= lv;
    end
    repeat (2 * bt + bt / 4) @(posedge clk);
    drv_en <= 1'b0;
    drv_o <= 1'b1;
  endtask : send

  // Decode the device reply; edge timing outside tolerance is counted
  task automatic recv(input int nb, output logic [15:0] d);
    logic last;
    int c;
    int i;
    d = 16'h0000;
    c = 0;
    while (dev_oe_n !== 1'b0 && c < 8 * bt) begin
      @(posedge clk);
      c++;
    end
    last = line;
    c = 0;
    while (line === last && c < 4 * bt) begin
      @(posedge clk);
      c++;
    end
    for (i = 0; i < nb; i++) begin
      last = line;
      c = 0;
      while (line === last && c < 2 * bt) begin
        @(posedge clk);
        c++;
      end
      if (c < bt * 3 / 4) begin
        if (c < bt * 2 / 5 || c > bt * 3 / 5) bad_time++;
        last = line;
        while (line === last && c < 2 * bt) begin
          @(posedge clk);
          c++;
        end
        d = {d[14:0], 1'b1};
      end else begin
        d = {d[14:0], 1'b0};
      end
      if (c < bt * 9 / 10 || c > bt * 11 / 10) bad_time++;
    end
    c = 0;
    while (dev_oe_n === 1'b0 && c < 4 * bt) begin
      @(posedge clk);
      c++;
    end
  endtask : recv
endmodule : link_prog_model

// file: link_top_tb.sv
// Self-checking bench for the output-pin programming link
`timescale 1ns/1ps
module link_top_tb;
  import link_pkg::*;
  // ------------------------------------------------------------
  // Signals and instances
  // ------------------------------------------------------------
  localparam int SLOW = 40;
  localparam int FAST = 16;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic app_level = 1'b0;
  logic [11:0] angle = 12'h000;
  logic [15:0] err_code = 16'h0000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, irq, pin_o, pin_oe_n, prog_mode, prog_o, prog_en;
  wire pin_wire;
  int num_errors = 0;
  int n_checks = 0;
  integer seed = 60;

  always #10 mclk = ~mclk;
  // Programmer overdrives the device; released wire rests on the pull-up
  assign pin_wire = prog_en ? prog_o : (!pin_oe_n ? pin_o : 1'b1);

  link_top #(.SLOW_CYC(SLOW), .FAST_CYC(FAST)) dut_u (.MCLK(mclk), .RESET_N(reset_n),
    .PIN_I(pin_wire), .PIN_O(pin_o), .PIN_OE_N(pin_oe_n), .APP_LEVEL(app_level),
    .ANGLE(angle), .ERR_CODE(err_code), .PROG_MODE(prog_mode), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .IRQ(irq));
  link_prog_model prog_u (.clk(mclk), .line(pin_wire), .dev_oe_n(pin_oe_n),
    .drv_o(prog_o), .drv_en(prog_en));

  // ------------------------------------------------------------
  // Tasks and expectation functions
  // ------------------------------------------------------------
  task check(input logic [32:0] seen, input logic [32:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task give_verdict;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : give_verdict

  // One APB transfer; data taken only at the edge where PREADY is seen
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
           output logic [31:0] rd, output logic er);
    int c;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    c = 0;
    do begin
      @(posedge mclk);
      c++;
    end while (pready !== 1'b1 && c < 50);
    if (pready !== 1'b1) num_errors++; // Bus timeout counts as a mismatch
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task link(input logic [2:0] cmd, input logic [2:0] adr, input logic [15:0] d,
            input int nb, output logic [15:0] r);
    prog_u.send({cmd, adr, d}, 22);
    prog_u.recv(nb, r);
  endtask : link

  // Errors clear the second acknowledge only while fault hold is set
  function automatic logic [1:0] exp_ack(input logic [2:0] cmd, input logic [2:0] adr,
                                         input logic hold);
    if (cmd != CMD_WRITE && cmd != CMD_STORE) return {1'b0, ~hold};
    if (cmd == CMD_WRITE && adr >= ADR_ANGLE) return {1'b1, ~hold};
    return 2'b11;
  endfunction : exp_ack

  // Hang guard sized well above the longest expected sequence
  initial begin
    repeat (90000) @(posedge mclk);
    num_errors++;
    give_verdict();
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    logic [31:0] rd;
    logic er;
    logic [15:0] r, d, cfg;
    int i, c;
    repeat (5) @(posedge mclk);
    reset_n <= 1'b1;
    for (i = 0; i < 8; i++) begin
      app_level <= $random(seed);
      angle <= $random(seed);
      err_code <= $random(seed);
      @(posedge mclk);
      @(posedge mclk);
      check(pin_o, app_level);
      check({prog_mode, pin_oe_n}, 2'b00);
    end
    for (i = 0; i < 4; i++) begin
      apb(1'b0, 8'(i * 4), 32'h0, rd, er);
      check({er, rd}, 33'h0);
    end
    apb(1'b0, 8'h10, 32'h0, rd, er);
    check({er, rd}, {1'b1, 32'h0});
    apb(1'b1, 8'hF0, 32'h5, rd, er);
    check(er, 1'b1);
    apb(1'b1, REG_IRQ_MASK, 32'hFFFFFFFF, rd, er);
    apb(1'b0, REG_IRQ_MASK, 32'h0, rd, er);
    check(rd, 32'hF);
    app_level <= 1'b0;
    prog_u.pulse(1'b1, ENTRY_CYC - 50);
    repeat (4) @(posedge mclk);
    check(prog_mode, 1'b0);
    prog_u.pulse(1'b1, ENTRY_CYC + 20);
    repeat (2 * SLOW) @(posedge mclk);
    check({prog_mode, pin_oe_n, irq}, 3'b111);
    apb(1'b0, REG_IRQ_STAT, 32'h0, rd, er);
    check(rd, 32'h1 << EV_ENTRY);
    apb(1'b1, REG_IRQ_STAT, 32'h1, rd, er);
    apb(1'b0, REG_IRQ_STAT, 32'h0, rd, er);
    check({irq, rd}, 33'h0);
    d = $random(seed);
    link(CMD_WRITE, 3'h1, d, 2, r);
    check(r[1:0], exp_ack(CMD_WRITE, 3'h1, 1'b0));
    link(CMD_READ, 3'h1, 16'h0, 16, r);
    check(r, d);
    link(CMD_READ, ADR_ANGLE, 16'h0, 16, r);
    check(r, {4'h0, angle});
    link(CMD_READ, ADR_DIAG, 16'h0, 16, r);
    check(r, err_code);
    cfg = 16'h0000 | (16'h1 << CFG_HOLD) | (16'h1 << CFG_CLAMP);
    link(CMD_WRITE, ADR_CFG, cfg, 2, r);
    check(r[1:0], 2'b11);
    link(CMD_STORE, ADR_CFG, 16'h0, 2, r);
    check(r[1:0], 2'b11);
    link(CMD_WRITE, ADR_ANGLE, 16'h1234, 2, r);
    check(r[1:0], exp_ack(CMD_WRITE, ADR_ANGLE, 1'b1));
    link(CMD_READ, ADR_PFAULT, 16'h0, 16, r);
    check(r[PF_ADR], 1'b1);
    link(CMD_READ, ADR_PFAULT, 16'h0, 16, r);
    check(r, 16'h0);
    cfg = cfg | (16'h1 << CFG_FAST);
    link(CMD_WRITE, ADR_CFG, cfg, 2, r);
    check(r[1:0], 2'b11);
    prog_u.send({CMD_STORE, ADR_CFG, 16'h0}, 22);
    prog_u.bt = FAST; // Stored bit 13 already paces this acknowledge
    prog_u.recv(2, r);
    check(r[1:0], 2'b11);
    for (c = 0; c < 8; c++) begin
      if (c == 0 || c > 3) begin
        link(3'(c), 3'h1, 16'h0, 2, r);
        check(r[1:0], exp_ack(3'(c), 3'h1, 1'b1));
      end
    end
    link(CMD_READ, 3'h1, 16'h0, 16, r);
    check(r, d);
    cfg = (16'h1 << CFG_LOCK) | (16'h1 << CFG_FAST) | (16'h1 << CFG_HOLD);
    link(CMD_WRITE, ADR_CFG, cfg, 2, r);
    check(r[1:0], 2'b11);
    link(CMD_STORE, ADR_CFG, 16'h0, 2, r);
    check(r[1:0], 2'b11);
    link(CMD_READ, ADR_CFG, 16'h0, 16, r);
    check(r[CFG_LOCK], 1'b1);
    apb(1'b0, REG_CFG, 32'h0, rd, er);
    check(rd, {16'h0, cfg});
    apb(1'b0, REG_STATE, 32'h0, rd, er);
    check(rd[1:0], 2'b11);
    link(CMD_WRITE, 3'h1, ~d, 2, r);
    check(r[1:0], 2'b10);
    link(CMD_STORE, ADR_CFG, 16'h0, 2, r);
    check(r[1:0], 2'b10);
    link(CMD_READ, 3'h1, 16'h0, 16, r);
    check(r, d);
    apb(1'b0, REG_IRQ_STAT, 32'h0, rd, er);
    check(rd[EV_STORE], 1'b1);
    apb(1'b1, REG_IRQ_STAT, 32'hF, rd, er);
    apb(1'b1, REG_IRQ_MASK, 32'h0, rd, er);
    prog_u.send(22'h0, 21);
    c = 0;
    for (i = 0; i < 4 * FAST; i++) begin
      @(posedge mclk);
      if (pin_oe_n !== 1'b1) c++;
    end
    check(c, 0);
    apb(1'b0, REG_IRQ_STAT, 32'h0, rd, er);
    check({irq, rd[EV_FAULT], rd[EV_STORE]}, 3'b010);
    apb(1'b1, REG_IRQ_MASK, 32'h1 << EV_FAULT, rd, er);
    repeat (3) @(posedge mclk);
    check(irq, 1'b1);
    check(prog_u.bad_time, 0);
    give_verdict();
  end
endmodule : link_top_tb
